/* File: smru_defs.svh */
`ifndef SMRU_DEFS_SVH
`define SMRU_DEFS_SVH
// ------------------------------------------------------------
// register indices; byte address is four times the index
// ------------------------------------------------------------
`define SMRU_IDX_ROUTE 12'hF0A
`define SMRU_IDX_CTRL 12'hF0B
`define SMRU_IDX_P2SEL 12'hF0C
`define SMRU_IDX_COMBO 12'hF0D
`define SMRU_IDX_P3SEL 12'hF0E
`define SMRU_ADDR_W 14
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define SMRU_BIT_FLAG 7
`define SMRU_BIT_LEVEL 6
`define SMRU_BIT_DELAY 5
`define SMRU_BIT_DIV16 0
`define SMRU_BIT_ROUTE 4
`define SMRU_CTRL_RST 8'h20
`define SMRU_CTRL_WMASK 8'h7D
`define SMRU_STOP_OPCODE 8'h6F
`define SMRU_RESTART_VEC 16'h000C
`define SMRU_SRC_NONE 3'h0
`define SMRU_SRC_RSVD 3'h1
`define SMRU_SRC_P31 3'h2
`define SMRU_SRC_P32 3'h3
`define SMRU_SRC_P33 3'h4
`define SMRU_SRC_P27 3'h5
`define SMRU_SRC_P2NOR 3'h6
`define SMRU_SRC_P2AND 3'h7
`define SMRU_LATCH_RD 2'h1
`define SMRU_LATCH_WR 2'h2
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SMRU_CLK_NS 100
`define SMRU_DELAY_NS 1600
`define SMRU_DELAY_CYC (`SMRU_DELAY_NS / `SMRU_CLK_NS)
`endif

/* File: smru_pkg.sv */
package smru_pkg;
   typedef enum logic [1:0] {
      SMRU_RUN = 2'b00,
      SMRU_STOP = 2'b01,
      SMRU_WAKE_DLY = 2'b10,
      SMRU_WAKE_RST = 2'b11
   } smru_state_t;
   typedef struct packed {
      logic [7:0] p2_pins;
      logic [3:0] p3_pins;
      logic [7:0] p2_is_out;
      logic [3:0] p3_is_out;
   } smru_port_t;
endpackage : smru_pkg

/* File: smru_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module smru_sync #(
   parameter int W = 12
) (
   input wire logic ref_clk, // clock
   input wire logic sys_rst, // async reset
   input wire logic [W-1:0] d, // raw pins
   output logic [W-1:0] q // synchronised
);
   logic [W-1:0] s1_reg;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_reg <= '0;
         q <= '0;
      end else begin
         s1_reg <= d;
         q <= s1_reg;
      end
   end
endmodule : smru_sync
`default_nettype wire

/* File: smru_change_det.sv */
`timescale 1ns/10ps
`default_nettype none
// pin-change source: reference follows port reads or writes
module smru_change_det #(
   parameter int W = 8
) (
   input wire logic ref_clk, // clock
   input wire logic sys_rst, // async reset
   input wire logic [W-1:0] pins, // pin levels, unsynchronised
   input wire logic [W-1:0] enable, // per-pin select
   input wire logic [W-1:0] is_out, // pin is an output
   input wire logic latch_rd, // port read pulse
   input wire logic latch_wr, // port write pulse
   input wire logic [W-1:0] wr_data, // port write value
   input wire logic [W-1:0] rd_data, // port value seen by read
   input wire logic use_ref, // latched reference valid
   output logic hit // combinational event
);
   logic [W-1:0] ref_reg;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) ref_reg <= '0;
      else if (latch_wr) ref_reg <= wr_data;
      else if (latch_rd) ref_reg <= rd_data;
   end
   // default behaviour: pin wakes on a zero; pins straight, no clock
   assign hit = |(enable & ~is_out &
      (use_ref ? (pins ^ ref_reg) : ~pins));
endmodule : smru_change_det
`default_nettype wire

/* File: smru_top.sv */
// How it works
// - stop opcode halts core clock and oscillator
// - leave stop only by reset, vector 000Ch
// - recovery reset keeps bits except divide-by-16, sets stop flag
// - delay bit zero skips power-on timer
// - route bit sends events to irq, port bit
// - event is OR of all sources
// - source field picks mode, compared with level
// - source codes 000 and 001 give nothing
// - main source ignores outputs, change-selected pins
// - port two change pins against reference
// - port three change pins against reference
// - combo register picks one of seven combinations
// - main source single port three pin, port two bit 7, or port two NOR/AND combos
// - status shows latch valid and read/write
// - stop flag read-only, shows last start kind
// - level bit zero low, one high
// - source field survives recovery reset
// - divide-by-16 cleared by both resets
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "smru_defs.svh"
module smru_top
   import smru_pkg::*;
#(
   parameter int DELAY_CYC = `SMRU_DELAY_CYC
) (
   input wire logic ref_clk, // 10 MHz clock
   input wire logic sys_rst, // power-on reset, async high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [`SMRU_ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [7:0] cpu_opcode, // opcode executing
   input wire logic cpu_op_valid, // opcode strobe
   input wire logic wdt_timeout, // watchdog timeout pulse
   input wire smru_port_t port_in, // pins and directions
   input wire logic p2_rd, // port 2 read pulse
   input wire logic p2_wr, // port 2 write pulse
   input wire logic p3_rd, // port 3 read pulse
   input wire logic p3_wr, // port 3 write pulse
   input wire logic [7:0] port_wdata, // port write value
   output logic clk_run, // core clock enable
   output logic osc_run, // oscillator enable
   output logic cpu_rst, // reset to core
   output logic [15:0] restart_addr, // restart vector
   output logic div16_en, // prescaler select
   output logic irq_one, // interrupt line one request
   output logic p3_bit3 // port three bit3, low on event
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      smru_state_t st;
      logic [7:0] ctrl;
      logic [7:0] p2sel;
      logic [7:0] combo;
      logic [3:0] p3sel;
      logic route;
      logic [1:0] latch;
      logic [15:0] cnt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic clk_run;
      logic cpu_rst;
      logic irq;
      logic p3b3;
   } smru_regs_t;
   smru_regs_t s_reg, s_next;
   smru_port_t pin_sync;
   logic wake, wake_ctrl, wake_combo, hit2, hit3;
   logic [7:0] p2, m2;
   logic [3:0] p3, m3;
   logic lvl;
   logic [11:0] idx;
   logic [2:0] src;
   logic use_ref;
   // async detection path from raw pins so wake works clockless
   assign p2 = port_in.p2_pins;
   assign p3 = port_in.p3_pins;
   // ignored pins can never match the level, so they never wake
   assign m2 = port_in.p2_is_out | s_reg.p2sel;
   assign m3 = port_in.p3_is_out | s_reg.p3sel;
   assign lvl = s_reg.ctrl[`SMRU_BIT_LEVEL];
   assign idx = paddr[`SMRU_ADDR_W-1:2];
   assign src = s_reg.ctrl[4:2];
   assign use_ref = (s_reg.latch != 2'h0);
   // ------------------------------------------------------------
   // sources
   // ------------------------------------------------------------
   smru_sync #(.W(24)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .d(port_in),
      .q(pin_sync)
   );
   smru_change_det #(.W(8)) u_p2 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pins(p2),
      .enable(s_reg.p2sel),
      .is_out(port_in.p2_is_out),
      .latch_rd(p2_rd),
      .latch_wr(p2_wr),
      .wr_data(port_wdata),
      .rd_data(pin_sync.p2_pins),
      .use_ref(use_ref),
      .hit(hit2)
   );
   smru_change_det #(.W(4)) u_p3 (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pins(p3),
      .enable(s_reg.p3sel),
      .is_out(port_in.p3_is_out),
      .latch_rd(p3_rd),
      .latch_wr(p3_wr),
      .wr_data(port_wdata[3:0]),
      .rd_data(pin_sync.p3_pins),
      .use_ref(use_ref),
      .hit(hit3)
   );
   always_comb begin
      logic lg;
      lg = 1'b0;
      case (src)
         `SMRU_SRC_P31: lg = m3[1] ? ~lvl : p3[1];
         `SMRU_SRC_P32: lg = m3[2] ? ~lvl : p3[2];
         `SMRU_SRC_P33: lg = m3[3] ? ~lvl : p3[3];
         `SMRU_SRC_P27: lg = m2[7] ? ~lvl : p2[7];
         `SMRU_SRC_P2NOR: lg = ~|(p2 & ~m2);
         `SMRU_SRC_P2AND: lg = &(p2 | m2);
         default: lg = 1'b0;
      endcase
      // 000 and 001 select nothing
      wake_ctrl = (src != `SMRU_SRC_NONE) && (src != `SMRU_SRC_RSVD)
         && (lg == s_reg.ctrl[`SMRU_BIT_LEVEL]);
   end
   // combo register: [2:0] mode (0 = off), bit 6 active level
   always_comb begin
      logic cl;
      cl = 1'b0;
      case (s_reg.combo[2:0])
         3'h1: cl = p3[1] & p3[2];
         3'h2: cl = p3[1] | p3[2];
         3'h3: cl = p3[3] ^ p2[0];
         3'h4: cl = &p2[3:0];
         3'h5: cl = |p2[7:4];
         3'h6: cl = p3[1] & ~p3[3];
         3'h7: cl = ^p2;
         default: cl = 1'b0;
      endcase
      wake_combo = (s_reg.combo[2:0] != 3'h0) && (cl == s_reg.combo[6]);
   end
   assign wake = wake_ctrl | wake_combo | hit2 | hit3;
   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic wr, rd;
      s_next = s_reg;
      wr = psel & penable & pwrite;
      rd = psel & ~penable & ~pwrite;
      s_next.pready = psel & ~penable;
      s_next.pslverr = 1'b0;
      s_next.cpu_rst = 1'b0;
      if (psel & ~penable) begin
         s_next.pslverr = (paddr[1:0] != 2'h0) ||
            !(idx inside {`SMRU_IDX_ROUTE, `SMRU_IDX_CTRL,
            `SMRU_IDX_P2SEL, `SMRU_IDX_COMBO, `SMRU_IDX_P3SEL});
      end
      if (rd) begin
         case (idx)
            `SMRU_IDX_ROUTE: s_next.prdata = {24'h0, 3'h0, s_reg.route,
               2'h0, s_reg.latch};
            `SMRU_IDX_CTRL: s_next.prdata = {24'h0, s_reg.ctrl};
            `SMRU_IDX_P2SEL: s_next.prdata = {24'h0, s_reg.p2sel};
            `SMRU_IDX_COMBO: s_next.prdata = {24'h0, s_reg.combo};
            `SMRU_IDX_P3SEL: s_next.prdata = {28'h0, s_reg.p3sel};
            default: s_next.prdata = 32'h0;
         endcase
      end
      // misaligned reads return zero
      if (rd && paddr[1:0] != 2'h0) s_next.prdata = 32'h0;
      if (wr && s_reg.pready && !s_reg.pslverr) begin
         case (idx)
            `SMRU_IDX_ROUTE: begin
               s_next.route = pwdata[`SMRU_BIT_ROUTE];
               s_next.latch = pwdata[1:0];
            end
            `SMRU_IDX_CTRL: s_next.ctrl = (s_reg.ctrl & ~`SMRU_CTRL_WMASK)
               | (pwdata[7:0] & `SMRU_CTRL_WMASK);
            `SMRU_IDX_P2SEL: s_next.p2sel = pwdata[7:0];
            `SMRU_IDX_COMBO: s_next.combo = pwdata[7:0];
            `SMRU_IDX_P3SEL: s_next.p3sel = pwdata[3:0];
            default: ;
         endcase
      end
      // a port access arms the reference and records its kind
      if (p2_wr | p3_wr) s_next.latch = `SMRU_LATCH_WR;
      else if (p2_rd | p3_rd) s_next.latch = `SMRU_LATCH_RD;
      s_next.irq = s_reg.route & wake;
      s_next.p3b3 = ~(s_reg.route & wake);
      case (s_reg.st)
         SMRU_RUN: begin
            if (cpu_op_valid && cpu_opcode == `SMRU_STOP_OPCODE) begin
               s_next.st = SMRU_STOP;
               s_next.clk_run = 1'b0;
            end
         end
         SMRU_STOP: begin
            if (wdt_timeout) begin
               s_next.st = SMRU_WAKE_RST;
               // watchdog is a full reset of the register set
               s_next.ctrl = `SMRU_CTRL_RST;
               s_next.p2sel = 8'h0;
               s_next.p3sel = 4'h0;
               s_next.combo = 8'h0;
               s_next.route = 1'b0;
               s_next.latch = 2'h0;
            end else if (wake) begin
               s_next.ctrl[`SMRU_BIT_FLAG] = 1'b1;
               s_next.ctrl[`SMRU_BIT_DIV16] = 1'b0;
               s_next.cnt = 16'h0;
               // src field kept as it stands
               s_next.st = s_reg.ctrl[`SMRU_BIT_DELAY] ?
                  SMRU_WAKE_DLY : SMRU_WAKE_RST;
            end
         end
         SMRU_WAKE_DLY: begin
            s_next.cnt = s_reg.cnt + 16'h1;
            if (s_reg.cnt >= 16'(DELAY_CYC - 1)) s_next.st = SMRU_WAKE_RST;
         end
         SMRU_WAKE_RST: begin
            s_next.cpu_rst = 1'b1;
            s_next.clk_run = 1'b1;
            s_next.st = SMRU_RUN;
         end
         default: s_next.st = SMRU_RUN;
      endcase
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.ctrl <= `SMRU_CTRL_RST;
         s_reg.clk_run <= 1'b1;
         s_reg.p3b3 <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign clk_run = s_reg.clk_run;
   assign osc_run = s_reg.clk_run;
   assign cpu_rst = s_reg.cpu_rst;
   assign restart_addr = `SMRU_RESTART_VEC;
   assign div16_en = s_reg.ctrl[`SMRU_BIT_DIV16];
   assign irq_one = s_reg.irq;
   assign p3_bit3 = s_reg.p3b3;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_stop_halts: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_reg.st == SMRU_RUN && cpu_op_valid && cpu_opcode == `SMRU_STOP_OPCODE
      |=> !clk_run && !osc_run) else $error("stop did not halt");
   a_flag_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_reg.st == SMRU_STOP && wake && !wdt_timeout
      |=> s_reg.ctrl[7]) else $error("flag not set");
   a_fast_wake: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_reg.st == SMRU_STOP && wake && !wdt_timeout && !s_reg.ctrl[5]
      |=> ##1 cpu_rst) else $error("fast wake slow");
   a_route_irq: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_reg.route && wake |=> irq_one && !p3_bit3)
      else $error("route missing");
   a_src_none: assert property (@(posedge ref_clk) disable iff (sys_rst)
      src inside {3'h0, 3'h1} |-> !wake_ctrl)
      else $error("reserved source fired");
   a_flag_ro: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_reg.st == SMRU_RUN ##1 s_reg.st == SMRU_RUN
      |-> $stable(s_reg.ctrl[7])) else $error("flag written");
   a_src_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_reg.st == SMRU_STOP && wake && !wdt_timeout
      |=> $stable(s_reg.ctrl[4:2])) else $error("source lost");
   a_div_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
      s_reg.st == SMRU_STOP && wake |=> !div16_en)
      else $error("prescaler kept");
endmodule : smru_top
`default_nettype wire

/* File: smru_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none
// far side: wake pin levels and their directions
module smru_pins_model
   import smru_pkg::*;
(
   input wire logic ref_clk, // clock
   output var smru_port_t port_in // pin levels to block
);
   int cyc = 0;
   int stamp = 0;
   initial port_in = '0;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
   end
   task automatic put(input smru_port_t v);
      @(posedge ref_clk);
      port_in <= v;
      stamp = cyc;
   endtask : put
   // a fast recovery would miss a source dropped too early
   task automatic put_held(input smru_port_t v);
      while (cyc - stamp < 10) @(posedge ref_clk);
      put(v);
   endtask : put_held
endmodule : smru_pins_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "smru_defs.svh"
module testbench
   import smru_pkg::*;
   ;
   localparam int DLY = 2;
   logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic cpu_op_valid = 0, wdt_timeout = 0, perr;
   logic p2_rd = 0, p2_wr = 0, p3_rd = 0, p3_wr = 0;
   logic [13:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdat;
   logic [7:0] cpu_opcode = '0, port_wdata = '0;
   logic pready, pslverr, clk_run, osc_run, cpu_rst, div16_en;
   logic irq_one, p3_bit3;
   logic [15:0] restart_addr;
   smru_port_t port_in;
   int err_count = 0, tests_run = 0, cyc = 0;
   always #50 ref_clk = ~ref_clk;
   smru_pins_model PINS (.ref_clk(ref_clk), .port_in(port_in));
   smru_top #(.DELAY_CYC(DLY)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_opcode(cpu_opcode),
      .cpu_op_valid(cpu_op_valid), .wdt_timeout(wdt_timeout),
      .port_in(port_in), .p2_rd(p2_rd), .p2_wr(p2_wr), .p3_rd(p3_rd),
      .p3_wr(p3_wr), .port_wdata(port_wdata), .clk_run(clk_run),
      .osc_run(osc_run), .cpu_rst(cpu_rst), .restart_addr(restart_addr),
      .div16_en(div16_en), .irq_one(irq_one), .p3_bit3(p3_bit3));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= {a, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      // look before the edge, so the value counts at that edge
      @(negedge ref_clk);
      while (pready !== 1'b1) @(negedge ref_clk);
      rdat = prdata;
      perr = pslverr;
      @(posedge ref_clk);
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic stop;
      @(posedge ref_clk);
      cpu_opcode <= 8'hFF;
      cpu_op_valid <= 1;
      @(posedge ref_clk);
      cpu_opcode <= `SMRU_STOP_OPCODE;
      @(posedge ref_clk);
      cpu_op_valid <= 0;
      repeat (2) @(posedge ref_clk);
      chk({clk_run, osc_run}, 0);
   endtask : stop
   task automatic wake(input smru_port_t v, output int n);
      n = 0;
      PINS.put(v);
      while (cpu_rst !== 1'b1 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      chk(restart_addr, `SMRU_RESTART_VEC);
   endtask : wake
   task automatic ev(input smru_port_t v, input logic e);
      PINS.put(v);
      repeat (4) @(posedge ref_clk);
      chk({irq_one, p3_bit3}, {e, ~e});
   endtask : ev
   // ------------------------------------------------------------
   // timeout and main sequence
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin : main
      int i, n0, n1;
      logic [7:0] tc [6] = '{8'h48, 8'h48, 8'h0C, 8'h0C, 8'h48, 8'h44};
      logic [23:0] tp [6] = '{24'h002000, 24'h0, 24'h00B000, 24'h00F000,
                              24'h002002, 24'h00F000};
      logic te [6] = '{1, 0, 1, 0, 0, 0};
      repeat (3) @(posedge ref_clk);
      sys_rst <= 0;
      apb(0, `SMRU_IDX_CTRL, 0);
      chk(rdat, `SMRU_CTRL_RST);
      apb(1, `SMRU_IDX_COMBO, 0);
      apb(1, `SMRU_IDX_CTRL, 32'hFF);
      apb(0, `SMRU_IDX_CTRL, 0);
      chk(rdat, 32'h7D);
      apb(0, 12'h000, 0);
      chk({perr, rdat[30:0]}, 32'h80000000);
      $display("test registers done");
      apb(1, `SMRU_IDX_ROUTE, 32'h10);
      for (i = 0; i < 6; i++) begin
         apb(1, `SMRU_IDX_CTRL, {24'h0, tc[i]});
         ev(tp[i], te[i]);
      end
      apb(1, `SMRU_IDX_CTRL, 0);
      apb(1, `SMRU_IDX_P2SEL, 1);
      @(posedge ref_clk);
      p2_wr <= 1;
      @(posedge ref_clk);
      p2_wr <= 0;
      ev(24'h0, 0);
      ev(24'h010000, 1);
      apb(0, `SMRU_IDX_ROUTE, 0);
      chk(rdat, 32'h12);
      apb(1, `SMRU_IDX_P2SEL, 0);
      apb(1, `SMRU_IDX_ROUTE, 0);
      PINS.put_held(0);
      $display("test events done");
      apb(1, `SMRU_IDX_CTRL, 32'h49);
      stop();
      wake(24'h002000, n0);
      PINS.put_held(0);
      apb(0, `SMRU_IDX_CTRL, 0);
      chk(rdat & 32'h9D, 32'h88);
      chk(div16_en, 0);
      apb(1, `SMRU_IDX_CTRL, 32'h69);
      stop();
      wake(24'h002000, n1);
      chk(n1 - n0, DLY);
      PINS.put_held(0);
      $display("test recovery done");
      for (i = 0; i < 2; i++) begin
         apb(1, `SMRU_IDX_CTRL, 32'h40 | (i << 2));
         PINS.put_held(24'hFFF000);
         stop();
         repeat (20) @(posedge ref_clk);
         chk(clk_run, 0);
         @(posedge ref_clk);
         wdt_timeout <= 1;
         @(posedge ref_clk);
         wdt_timeout <= 0;
         n0 = 0;
         while (clk_run !== 1'b1 && n0 < 40) begin
            @(posedge ref_clk);
            n0++;
         end
         apb(0, `SMRU_IDX_CTRL, 0);
         chk(rdat, `SMRU_CTRL_RST);
         PINS.put_held(0);
      end
      $display("test watchdog exit done");
      end_sim();
   end
endmodule : testbench
`default_nettype wire
